// >>> logic/twu_unlock.v
// timed write unlock guarding the critical control bits
`timescale 1ns/1ps
`include "twu_regs.vh"
module twu_unlock (
    // clock and reset
    input wire clk,
    input wire nrst,
    // core special function register write path
    input wire sfr_wr,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    // one pulse per machine cycle from the core sequencer
    input wire mc_tick,
    // write attempts to the protected bits
    input wire wdt_ctl_wr,
    input wire [7:0] wdt_ctl_wdata,
    input wire rom_size_wr,
    input wire [2:0] rom_size_wdata,
    input wire wait_ctl_wr,
    input wire wait_ctl_wdata,
    input wire por_flag_wr,
    input wire por_flag_wdata,
    // hardware set of the power-on/fail flag
    input wire por_flag_set,
    // protected bits and window state
    output reg [7:0] wdt_ctl_r,
    output reg [2:0] rom_size_r,
    output reg wait_ctl_r,
    output reg por_flag_r,
    output reg window_open_r
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_OPEN = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] cnt_r;
    reg [1:0] cnt_nxt;
    reg window_open_nxt;
    reg [7:0] wdt_ctl_nxt;
    reg [2:0] rom_size_nxt;
    reg wait_ctl_nxt;
    reg por_flag_nxt;
    wire key_wr;
    wire key_first;
    wire key_second;
    wire key_other;
    wire cnt_last;
    wire win;

    // write to the unlock key register carrying a given value
    function key_is;
        input wr;
        input [7:0] addr;
        input [7:0] data;
        input [7:0] key;
        begin
            key_is = wr && (addr == `TWU_KEY_ADDR) && (data == key);
        end
    endfunction

    // a machine cycle boundary that uses up the last count
    function cnt_ends;
        input tick;
        input [1:0] cnt;
        begin
            cnt_ends = tick && (cnt == `TWU_CNT_ONE);
        end
    endfunction

    // count down one machine cycle, holding at zero
    function [1:0] cnt_step;
        input tick;
        input [1:0] cnt;
        begin
            if (tick && (cnt != `TWU_CNT_ZERO)) begin
                cnt_step = cnt - `TWU_CNT_ONE;
            end else begin
                cnt_step = cnt;
            end
        end
    endfunction

    // a protected write goes through only inside the window
    function wr_ok;
        input wr;
        input open;
        begin
            wr_ok = wr && open;
        end
    endfunction

    assign key_wr = sfr_wr && (sfr_addr == `TWU_KEY_ADDR);
    assign key_first = key_is(sfr_wr, sfr_addr, sfr_wdata, `TWU_KEY_FIRST);
    assign key_second = key_is(sfr_wr, sfr_addr, sfr_wdata, `TWU_KEY_SECOND);
    assign key_other = key_wr && !key_first && !key_second;
    assign cnt_last = cnt_ends(mc_tick, cnt_r);
    assign win = (state_r == ST_OPEN);

    // sequence: idle, waiting for second key, window open
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                // a lone second key is ignored here
                if (key_first) begin
                    state_nxt = ST_ARMED;
                    cnt_nxt = `TWU_ARM_MC;
                end
            end
            ST_ARMED: begin
                // a key write in the cycle of a tick wins over the tick
                if (key_second) begin
                    state_nxt = ST_OPEN;
                    cnt_nxt = `TWU_OPEN_MC;
                end else if (key_first) begin
                    cnt_nxt = `TWU_ARM_MC;
                end else if (key_other) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = `TWU_CNT_ZERO;
                end else if (cnt_last) begin
                    // wait expired: a late second key finds the block idle
                    state_nxt = ST_IDLE;
                    cnt_nxt = `TWU_CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_step(mc_tick, cnt_r);
                end
            end
            ST_OPEN: begin
                // a fresh first key closes the window and restarts the wait
                if (key_first) begin
                    state_nxt = ST_ARMED;
                    cnt_nxt = `TWU_ARM_MC;
                end else if (cnt_last) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = `TWU_CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_step(mc_tick, cnt_r);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = `TWU_CNT_ZERO;
            end
        endcase
        window_open_nxt = (state_nxt == ST_OPEN);
    end

    // protected bits: writes outside the window are dropped
    always @* begin
        wdt_ctl_nxt = wdt_ctl_r;
        rom_size_nxt = rom_size_r;
        wait_ctl_nxt = wait_ctl_r;
        por_flag_nxt = por_flag_r;
        if (wr_ok(wdt_ctl_wr, win)) begin
            wdt_ctl_nxt = wdt_ctl_wdata;
        end
        if (wr_ok(rom_size_wr, win)) begin
            rom_size_nxt = rom_size_wdata;
        end
        if (wr_ok(wait_ctl_wr, win)) begin
            wait_ctl_nxt = wait_ctl_wdata;
        end
        // hardware set wins over a software clear in the same cycle
        if (por_flag_set) begin
            por_flag_nxt = `TWU_POR_SET;
        end else if (wr_ok(por_flag_wr, win)) begin
            por_flag_nxt = por_flag_wdata;
        end
    end

    // sequence state and machine cycle counter
    always @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            cnt_r <= `TWU_CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // window flag follows the open state from its own flip-flop
    always @(posedge clk) begin
        if (!nrst) begin
            window_open_r <= `TWU_WIN_RST;
        end else begin
            window_open_r <= window_open_nxt;
        end
    end

    // watchdog control bits
    always @(posedge clk) begin
        if (!nrst) begin
            wdt_ctl_r <= `TWU_WDT_RST;
        end else begin
            wdt_ctl_r <= wdt_ctl_nxt;
        end
    end

    // program memory size setting
    always @(posedge clk) begin
        if (!nrst) begin
            rom_size_r <= `TWU_ROM_RST;
        end else begin
            rom_size_r <= rom_size_nxt;
        end
    end

    // wait state control
    always @(posedge clk) begin
        if (!nrst) begin
            wait_ctl_r <= `TWU_WAIT_RST;
        end else begin
            wait_ctl_r <= wait_ctl_nxt;
        end
    end

    // power-on/power-fail flag
    always @(posedge clk) begin
        if (!nrst) begin
            por_flag_r <= `TWU_POR_RST;
        end else begin
            por_flag_r <= por_flag_nxt;
        end
    end

endmodule // twu_unlock

// >>> shared/twu_regs.vh
// constants of the timed write unlock block
`ifndef TWU_REGS_VH
`define TWU_REGS_VH
`define TWU_KEY_ADDR 8'hC7
`define TWU_KEY_FIRST 8'hAA
`define TWU_KEY_SECOND 8'h55
`define TWU_ARM_MC 2'h3
`define TWU_OPEN_MC 2'h3
`define TWU_CNT_ZERO 2'h0
`define TWU_CNT_ONE 2'h1
`define TWU_WIN_RST 1'h0
`define TWU_POR_SET 1'h1
`define TWU_WDT_RST 8'h00
`define TWU_ROM_RST 3'h0
`define TWU_WAIT_RST 1'h0
`define TWU_POR_RST 1'h0
`endif

// >>> test/twu_unlock_checker.sv
// timed write unlock assertions
`timescale 1ns/1ps
module twu_unlock_checker (input wire clk, nrst, sfr_wr, mc_tick, por_flag_set,
    wait_ctl_r, por_flag_r, window_open_r, wait_ctl_wr, wait_ctl_wdata,
    input wire [7:0] sfr_addr, sfr_wdata, wdt_ctl_r, input wire [2:0] rom_size_r);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire o = window_open_r;
    wire k2 = sfr_wr && sfr_addr == 8'hC7 && sfr_wdata == 8'h55;
    // ticks since first key, 3 once expired or not armed
    reg [1:0] t_r, c_r;
    always @(posedge clk) begin
        c_r <= o ? c_r + {1'b0, mc_tick} : 2'h0;
        if (!nrst || (sfr_wr && sfr_addr == 8'hC7))
            t_r <= {2{!nrst || sfr_wdata != 8'hAA}};
        else if (mc_tick && t_r != 2'h3) t_r <= t_r + 2'h1;
    end
    property p_lock; !o && !por_flag_set |=> $stable({wdt_ctl_r, rom_size_r, wait_ctl_r,
        por_flag_r}); endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_rise; $rose(o) |-> $past(k2); endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_open; k2 && t_r != 2'h3 |=> o; endproperty
    a_open: assert property (p_open) else $error("open");
    property p_rej; k2 && !o && t_r == 2'h3 |=> !o; endproperty
    a_rej: assert property (p_rej) else $error("reject");
    property p_close; o && mc_tick && c_r == 2'h2 && !sfr_wr |=> !o; endproperty
    a_close: assert property (p_close) else $error("close");
    property p_wr; o && wait_ctl_wr |=> wait_ctl_r == $past(wait_ctl_wdata); endproperty
    a_wr: assert property (p_wr) else $error("window write lost");
    property p_por; por_flag_set |=> por_flag_r; endproperty
    a_por: assert property (p_por) else $error("flag set lost");
endmodule // twu_unlock_checker

// >>> test/testbench.sv
// timed write unlock bench
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
    logic clk = 0, nrst = 0, sw = 0, mt = 0, pw = 0, ps = 0, ok;
    logic [7:0] sa = 0, sd = 0;
    logic [12:0] v = 0, e = 0;
    logic [31:0] rs = 32'hA44D;
    wire [13:0] q;
    int err_total = 0, num_checks = 0, n = 0;
    twu_unlock u_twu_unlock (.clk(clk), .nrst(nrst), .sfr_wr(sw), .sfr_addr(sa), .sfr_wdata(sd),
        .mc_tick(mt), .wdt_ctl_wr(pw), .wdt_ctl_wdata(v[12:5]), .rom_size_wr(pw),
        .rom_size_wdata(v[4:2]), .wait_ctl_wr(pw), .wait_ctl_wdata(v[1]), .por_flag_wr(pw),
        .por_flag_wdata(v[0]), .por_flag_set(ps), .wdt_ctl_r(q[13:6]), .rom_size_r(q[5:3]),
        .wait_ctl_r(q[2]), .por_flag_r(q[1]), .window_open_r(q[0]));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (++n > 999) begin err_total++; stop_test; end
    function logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // ordered pair at the key address with fewer than 3 ticks and no stray write between
    function logic exp_open(int g, logic x, logic [7:0] a);
        return g < 3 && !(x && g > 0) && a == 8'hC7;
    endfunction
    task cy(logic w, logic [7:0] a, d, logic t, p);
        @(posedge clk) {sw, sa, sd, mt, pw} <= {w, a, d, t, p};
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // g ticks between keys, x writes a stray value meanwhile, a is the second key address
    task run(int g, logic x, logic [7:0] a);
        ok = exp_open(g, x, a);
        rs = xs(rs);
        v <= rs[12:0];
        if (ok) e = rs[12:0];
        cy(1, 8'hC7, 8'hAA, 0, 0);
        repeat (g) cy(x, 8'hC7, 8'h33, 1, 0);
        cy(1, a, 8'h55, 0, 0); cy(0, 0, 0, 0, 0); cy(0, 0, 0, 0, 1); cy(0, 0, 0, 0, 0);
        #1 `CHK("bits", {e, ok}, q)
        repeat (3) cy(0, 0, 0, 1, 0);
        cy(0, 0, 0, 0, 0);
        #1 `CHK("shut", 1'b0, q[0])
        $display("run %0d done", g);
    endtask
    // hardware set of the flag against a software clear in the same cycle
    task hw_set;
        rs = xs(rs);
        v <= {rs[12:1], 1'b0};
        e = {rs[12:1], 1'b1};
        cy(1, 8'hC7, 8'hAA, 0, 0);
        cy(1, 8'hC7, 8'h55, 0, 0);
        cy(0, 0, 0, 0, 0);
        cy(0, 0, 0, 0, 1);
        ps <= 1;
        cy(0, 0, 0, 0, 0);
        ps <= 0;
        #1 `CHK("por", {e, 1'b1}, q)
        repeat (3) cy(0, 0, 0, 1, 0);
        cy(0, 0, 0, 0, 0);
        #1 `CHK("close", 1'b0, q[0])
        $display("por set done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1;
        for (int g = 0; g < 5; g++) run(g, 0, 8'hC7);
        run(1, 1, 8'hC7);
        run(0, 0, 8'hC6);
        run(0, 1, 8'hC7);
        repeat (6) begin
            rs = xs(rs);
            run(rs[18:16] % 5, rs[20], 8'hC7);
        end
        hw_set;
        // reset in mid-run while the window stands open
        cy(1, 8'hC7, 8'hAA, 0, 0);
        cy(1, 8'hC7, 8'h55, 0, 0);
        cy(0, 0, 0, 0, 0);
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        e = 0;
        #1 `CHK("reset", 14'h0, q)
        $display("reset done");
        run(2, 0, 8'hC7);
        stop_test;
    end
endmodule // testbench
bind twu_unlock twu_unlock_checker u_twu_unlock_checker (.*);
